// file: src/smac_pkg.sv
/*
  Constants for the secure memory access control block: the core address
  map, the register offsets, field positions, reset values and the APB
  phase encoding.
  Assumes a 32-bit core address space and a 12-bit APB register window.
*/
package smac_pkg;

  // partition count; the first NUM_FLASH_PART entries guard flash
  localparam int unsigned NUM_PART       = 4;
  localparam int unsigned NUM_FLASH_PART = 2;
  localparam int unsigned IDX_W          = 2;

  // core address map
  localparam logic [31:0] ROM_BASE    = 32'h0000_0000;
  localparam logic [31:0] ROM_LIMIT   = 32'h0000_ffff;
  localparam logic [31:0] FLASH_BASE  = 32'h0010_0000;
  localparam logic [31:0] FLASH_LIMIT = 32'h001f_ffff;
  localparam logic [31:0] RAM_BASE    = 32'h0020_0000;
  localparam logic [31:0] RAM_LIMIT   = 32'h0020_3fff;
  localparam logic [31:0] SFR_BASE    = 32'h0040_0000;
  localparam logic [31:0] SFR_LIMIT   = 32'h0040_0fff;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MASK   = 12'h008;
  localparam logic [11:0] OFS_LAST   = 12'h00c;
  localparam logic [5:0]  PART_BLK   = 6'h01;   // partitions at 0x040..0x07f
  localparam logic [1:0]  FLD_BASE   = 2'h0;
  localparam logic [1:0]  FLD_LIMIT  = 2'h1;
  localparam logic [1:0]  FLD_ATTR   = 2'h2;

  // control register fields
  localparam int unsigned CTL_BOOT_FLASH = 0;
  localparam int unsigned CTL_BOOT_LOCK  = 1;
  localparam int unsigned CTL_FLASH_WE   = 2;
  localparam int unsigned CTL_ROM_USER   = 3;
  localparam int unsigned CTRL_W         = 4;
  localparam logic [3:0]  CTRL_RST       = 4'h0;

  // status and mask fields
  localparam int unsigned ST_PROHIB    = 0;
  localparam int unsigned ST_INVALID   = 1;
  localparam int unsigned ST_FLASH_WR  = 2;
  localparam int unsigned ST_REG_DENY  = 3;
  localparam int unsigned ST_USER_VIOL = 4;
  localparam int unsigned ST_W         = 5;
  localparam logic [4:0]  STATUS_RST   = 5'h00;
  localparam logic [4:0]  MASK_RST     = 5'h00;

  // partition attribute fields
  localparam int unsigned AT_EN     = 0;
  localparam int unsigned AT_UREAD  = 1;
  localparam int unsigned AT_UWRITE = 2;
  localparam int unsigned AT_W      = 3;
  localparam logic [2:0]  ATTR_RST  = 3'h0;
  localparam logic [31:0] BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
  localparam logic [31:0] LAST_RST  = 32'h0000_0000;

  // pprot bit that marks a privileged register access
  localparam int unsigned PROT_PRIV = 0;

  // apb slave phase
  typedef enum logic [1:0] {
    SMAC_APB_IDLE = 2'b01,
    SMAC_APB_ANS  = 2'b10
  } smac_apb_st_t;

endpackage : smac_pkg

// file: src/smac_region_check.sv
/*
  One partition comparator: says whether an address lies inside an
  enabled partition whose attribute lets user code make the access.
  Assumes base and limit are inclusive byte addresses, base <= limit.
*/
module smac_region_check (
  input  wire logic [31:0]             addr_i,
  input  wire logic [31:0]             base_i,
  input  wire logic [31:0]             limit_i,
  input  wire logic [smac_pkg::AT_W-1:0] attr_i,
  input  wire logic                    write_i,
  output logic                         ok_o
);

  logic in_range;
  logic perm;

  // window compare and permission select
  assign in_range = (addr_i >= base_i) && (addr_i <= limit_i);
  assign perm     = write_i ? attr_i[smac_pkg::AT_UWRITE]
                            : attr_i[smac_pkg::AT_UREAD];
  assign ok_o     = in_range & perm & attr_i[smac_pkg::AT_EN];

endmodule : smac_region_check

// file: src/smac_top.sv
/*
  Secure memory access control: judges each core access against the
  address map, the partition table and flash write protection, drives boot
  selection, and holds the security registers behind an APB slave.
  Assumes the core holds one request per cycle, APB accesses carry pprot,
  and all inputs are synchronous to core_clk_i.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
// Notes on behaviour
// [R1] accesses to prohibited areas are trapped
// [R2] security registers need privileged access attributes
// [R3] invalid addresses are detected and flagged
// [R4] software selects ROM or flash boot
// [R5] flash writes are refused unless enabled
// [R6] decisions depend on privilege or user mode
// [R7] all registers take defaults at reset
// [R8] ROM and flash attributes start at defaults
// [R9] software partitions memory with own attributes
// [R10] ROM user access is software controlled
// [R11] flash partitions carry individual attributes
// [R12] base, limit, attribute registers per partition
// [R13] boot choice frozen once locked to flash
// [R14] user misses are blocked, privilege bypasses
module smac_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // core access port
  input  wire logic        core_req_i,
  input  wire logic [31:0] core_addr_i,
  input  wire logic        core_write_i,
  input  wire logic        core_priv_i,
  output logic             core_done_o,
  output logic             core_grant_o,
  output logic             core_trap_o,
  output logic             invalid_addr_o,
  // boot selection and interrupt
  output logic             boot_flash_o,
  output logic             boot_locked_o,
  output logic             irq_o,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [2:0]  pprot_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  localparam int unsigned NP = smac_pkg::NUM_PART;
  localparam int unsigned NF = smac_pkg::NUM_FLASH_PART;
  localparam int unsigned AW = smac_pkg::AT_W;
  localparam int unsigned IDX_BITS = smac_pkg::IDX_W;

  smac_pkg::smac_apb_st_t apb_st;
  smac_pkg::smac_apb_st_t next_apb_st;

  logic [smac_pkg::CTRL_W-1:0] ctrl;
  logic [smac_pkg::ST_W-1:0]   status;
  logic [smac_pkg::ST_W-1:0]   mask;
  logic [31:0]                 last_addr;
  logic [31:0]                 part_base  [NP];
  logic [31:0]                 part_limit [NP];
  logic [AW-1:0]               part_attr  [NP];
  logic [NP-1:0]               part_ok;

  // core area decode
  logic in_rom;
  logic in_flash;
  logic in_ram;
  logic in_sfr;
  logic any_area;
  assign in_rom   = (core_addr_i >= smac_pkg::ROM_BASE) &&
                    (core_addr_i <= smac_pkg::ROM_LIMIT);
  assign in_flash = (core_addr_i >= smac_pkg::FLASH_BASE) &&
                    (core_addr_i <= smac_pkg::FLASH_LIMIT);
  assign in_ram   = (core_addr_i >= smac_pkg::RAM_BASE) &&
                    (core_addr_i <= smac_pkg::RAM_LIMIT);
  assign in_sfr   = (core_addr_i >= smac_pkg::SFR_BASE) &&
                    (core_addr_i <= smac_pkg::SFR_LIMIT);
  assign any_area = in_rom | in_flash | in_ram | in_sfr;

  // partition outcome per memory
  logic flash_ok;
  logic ram_ok;
  assign flash_ok = |part_ok[NF-1:0];                         // [R11]
  assign ram_ok   = |part_ok[NP-1:NF];                        // [R9]

  // access verdict
  logic user;
  logic ev_prohib;
  logic ev_invalid;
  logic ev_flash_wr;
  logic ev_user_viol;
  logic trap_now;
  assign user       = ~core_priv_i;                           // [R6]
  assign ev_invalid = core_req_i & ~any_area;                 // [R3]
  assign ev_prohib  = core_req_i & user &                     // [R1]
                      (in_sfr |                               // [R1]
                       (in_rom & ~ctrl[smac_pkg::CTL_ROM_USER])); // [R10]
  assign ev_flash_wr = core_req_i & in_flash & core_write_i & // [R5]
                       ~ctrl[smac_pkg::CTL_FLASH_WE];
  assign ev_user_viol = core_req_i & user &                   // [R14]
                        ((in_flash & ~flash_ok) | (in_ram & ~ram_ok));
  assign trap_now = ev_invalid | ev_prohib | ev_flash_wr | ev_user_viol;

  // apb decode, taken in the setup cycle
  logic setup;
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic sel_last;
  logic sel_part;
  logic mapped;
  logic deny;
  logic apb_err;
  logic [IDX_BITS-1:0] pidx;
  logic [1:0]          pfld;
  assign setup      = psel_i & ~penable_i;
  assign pidx       = paddr_i[5:4];
  assign pfld       = paddr_i[3:2];
  assign sel_ctrl   = paddr_i == smac_pkg::OFS_CTRL;
  assign sel_status = paddr_i == smac_pkg::OFS_STATUS;
  assign sel_mask   = paddr_i == smac_pkg::OFS_MASK;
  assign sel_last   = paddr_i == smac_pkg::OFS_LAST;
  assign sel_part   = (paddr_i[11:6] == smac_pkg::PART_BLK) &&
                      (pfld != 2'h3) && (paddr_i[1:0] == 2'h0);
  assign mapped     = sel_ctrl | sel_status | sel_mask | sel_last | sel_part;
  assign deny       = mapped & ~pprot_i[smac_pkg::PROT_PRIV];  // [R2]
  assign apb_err    = ~mapped | deny;

  // read data select
  logic [31:0] part_rd;
  logic [31:0] rdata;
  assign part_rd = (pfld == smac_pkg::FLD_BASE)  ? part_base[pidx]  :
                   (pfld == smac_pkg::FLD_LIMIT) ? part_limit[pidx] :
                   {{(32-AW){1'b0}}, part_attr[pidx]};
  assign rdata = sel_ctrl   ? {{(32-smac_pkg::CTRL_W){1'b0}}, ctrl}   :
                 sel_status ? {{(32-smac_pkg::ST_W){1'b0}}, status}   :
                 sel_mask   ? {{(32-smac_pkg::ST_W){1'b0}}, mask}     :
                 sel_last   ? last_addr                               :
                 sel_part   ? part_rd : 32'h0000_0000;

  // write strobes, at the access edge that completes the transfer
  logic fire_wr;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_part;
  assign fire_wr   = (apb_st == smac_pkg::SMAC_APB_ANS) & psel_i &
                     penable_i & pwrite_i & ~pslverr_o;
  assign wr_ctrl   = fire_wr & sel_ctrl;
  assign wr_status = fire_wr & sel_status;
  assign wr_mask   = fire_wr & sel_mask;
  assign wr_part   = fire_wr & sel_part;

  // boot selection with lock
  logic locked;
  logic [smac_pkg::CTRL_W-1:0] next_ctrl;
  assign locked = ctrl[smac_pkg::CTL_BOOT_LOCK] &
                  ctrl[smac_pkg::CTL_BOOT_FLASH];
  assign next_ctrl[smac_pkg::CTL_BOOT_FLASH] = locked ?       // [R13]
         ctrl[smac_pkg::CTL_BOOT_FLASH] :
         pwdata_i[smac_pkg::CTL_BOOT_FLASH];                  // [R4]
  assign next_ctrl[smac_pkg::CTL_BOOT_LOCK] = locked |        // [R13]
         (pwdata_i[smac_pkg::CTL_BOOT_LOCK] &
          pwdata_i[smac_pkg::CTL_BOOT_FLASH]);
  assign next_ctrl[smac_pkg::CTL_FLASH_WE] =
         pwdata_i[smac_pkg::CTL_FLASH_WE];                    // [R5]
  assign next_ctrl[smac_pkg::CTL_ROM_USER] =
         pwdata_i[smac_pkg::CTL_ROM_USER];                    // [R10]

  // sticky events; a set in the clearing cycle wins
  logic [smac_pkg::ST_W-1:0] ev_set;
  logic [smac_pkg::ST_W-1:0] st_clr;
  logic [smac_pkg::ST_W-1:0] next_status;
  assign ev_set[smac_pkg::ST_PROHIB]    = ev_prohib;
  assign ev_set[smac_pkg::ST_INVALID]   = ev_invalid;
  assign ev_set[smac_pkg::ST_FLASH_WR]  = ev_flash_wr;
  assign ev_set[smac_pkg::ST_REG_DENY]  = setup & deny;
  assign ev_set[smac_pkg::ST_USER_VIOL] = ev_user_viol;
  assign st_clr      = wr_status ? pwdata_i[smac_pkg::ST_W-1:0]
                                 : {smac_pkg::ST_W{1'b0}};
  assign next_status = (status & ~st_clr) | ev_set;
  assign next_apb_st = setup ? smac_pkg::SMAC_APB_ANS
                             : smac_pkg::SMAC_APB_IDLE;

  // partition registers and comparators
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_part
      logic wr_this;
      assign wr_this = wr_part & (pidx == IDX_BITS'(gi));

      // base, limit and attribute of one partition
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          part_base[gi]  <= smac_pkg::BASE_RST;               // [R8]
          part_limit[gi] <= smac_pkg::LIMIT_RST;
          part_attr[gi]  <= smac_pkg::ATTR_RST;
        end else if (wr_this) begin
          case (pfld)                                         // [R12]
            smac_pkg::FLD_BASE:  part_base[gi]  <= pwdata_i;
            smac_pkg::FLD_LIMIT: part_limit[gi] <= pwdata_i;
            smac_pkg::FLD_ATTR:  part_attr[gi]  <= pwdata_i[AW-1:0];
            default:             part_attr[gi]  <= part_attr[gi];
          endcase
        end
      end

      smac_region_check u_check (
        .addr_i  (core_addr_i),
        .base_i  (part_base[gi]),
        .limit_i (part_limit[gi]),
        .attr_i  (part_attr[gi]),
        .write_i (core_write_i),
        .ok_o    (part_ok[gi])
      );
    end
  endgenerate

  // control, status and mask registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl   <= smac_pkg::CTRL_RST;                           // [R7]
      status <= smac_pkg::STATUS_RST;
      mask   <= smac_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (wr_mask) begin
        mask <= pwdata_i[smac_pkg::ST_W-1:0];
      end
      status <= next_status;
    end
  end

  // address of the most recent trapped access
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_addr <= smac_pkg::LAST_RST;
    end else if (trap_now) begin
      last_addr <= core_addr_i;
    end
  end

  // registered core verdict, one cycle after the request
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_done_o    <= 1'b0;
      core_grant_o   <= 1'b0;
      core_trap_o    <= 1'b0;
      invalid_addr_o <= 1'b0;
    end else begin
      core_done_o    <= core_req_i;
      core_grant_o   <= core_req_i & ~trap_now;               // [R1]
      core_trap_o    <= trap_now;                             // [R14]
      invalid_addr_o <= ev_invalid;                           // [R3]
    end
  end

  // boot outputs follow the control register as it will be
  logic next_boot;
  logic next_lock;
  assign next_boot = wr_ctrl ? next_ctrl[smac_pkg::CTL_BOOT_FLASH]
                             : ctrl[smac_pkg::CTL_BOOT_FLASH];
  assign next_lock = wr_ctrl ? (next_ctrl[smac_pkg::CTL_BOOT_LOCK] &
                                next_ctrl[smac_pkg::CTL_BOOT_FLASH])
                             : locked;

  // boot outputs and interrupt level
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_flash_o  <= 1'b0;
      boot_locked_o <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      boot_flash_o  <= next_boot;                             // [R4]
      boot_locked_o <= next_lock;
      irq_o         <= |(next_status & mask);
    end
  end

  // apb answer, one access cycle with no wait state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      apb_st    <= smac_pkg::SMAC_APB_IDLE;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      apb_st    <= next_apb_st;
      pready_o  <= setup;
      pslverr_o <= setup & apb_err;                           // [R2]
      prdata_o  <= (setup & ~apb_err & ~pwrite_i) ? rdata : 32'h0000_0000;
    end
  end

  // checks on the behaviour above
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  prohib_trap_a: assert property (                            // [R1]
    core_req_i & user & in_sfr |=> core_trap_o & ~core_grant_o & core_done_o)
    else $error("user access to register area not trapped");
  reg_deny_a: assert property (                               // [R2]
    setup & ~pprot_i[smac_pkg::PROT_PRIV] |=> pready_o & pslverr_o)
    else $error("unprivileged register access not refused");
  invalid_flag_a: assert property (                           // [R3]
    ev_invalid |=> invalid_addr_o & status[smac_pkg::ST_INVALID])
    else $error("invalid address not reported");
  boot_select_a: assert property (                            // [R4]
    wr_ctrl & ~locked |=>
    boot_flash_o == $past(pwdata_i[smac_pkg::CTL_BOOT_FLASH]))
    else $error("boot selection not taken from write");
  flash_wp_a: assert property (                               // [R5]
    core_req_i & in_flash & core_write_i &
    ~ctrl[smac_pkg::CTL_FLASH_WE] |=> core_trap_o &
    status[smac_pkg::ST_FLASH_WR])
    else $error("protected flash write not refused");
  priv_bypass_a: assert property (                            // [R6]
    core_req_i & core_priv_i & (in_ram | (in_flash & ~core_write_i))
    |=> core_grant_o)
    else $error("privileged access blocked");
  reset_dflt_a: assert property (                             // [R7]
    $past(rst_i) |-> ctrl == smac_pkg::CTRL_RST && ~boot_flash_o &&
    part_attr[0] == smac_pkg::ATTR_RST)
    else $error("register not at default after reset");
  rom_user_a: assert property (                               // [R10]
    core_req_i & user & in_rom & ~ctrl[smac_pkg::CTL_ROM_USER]
    |=> core_trap_o)
    else $error("hidden rom reached by user code");
  boot_lock_a: assert property (                              // [R13]
    boot_locked_o |=> (boot_locked_o & boot_flash_o) [*2])
    else $error("locked boot selection changed");
  user_viol_a: assert property (                              // [R14]
    core_req_i & user & in_ram & ~ram_ok |=> core_trap_o &
    status[smac_pkg::ST_USER_VIOL])
    else $error("user partition miss not blocked");
  irq_level_a: assert property (
    |(status & mask) & ~wr_status |=> irq_o)
    else $error("interrupt missing for unmasked event");

  grant_user_c: cover property (core_req_i & user & in_ram ##1 core_grant_o);
  trap_c:       cover property (core_trap_o ##1 irq_o);
  lock_c:       cover property (wr_ctrl ##1 boot_locked_o);
  part_wr_c:    cover property (wr_part ##1 core_req_i & user & in_flash);

endmodule : smac_top

// file: testbench/smac_core_bfm.sv
/*
  Core model: issues one access at a time on the core port and returns
  the verdict that the block gives for it.
  Assumes the core port timing of smac_top and one shared clock.
*/
module smac_core_bfm (
  input  wire logic        clk_i,
  input  wire logic        done_i,
  input  wire logic        grant_i,
  input  wire logic        trap_i,
  input  wire logic        inv_i,
  output logic             req_o,
  output logic [31:0]      addr_o,
  output logic             write_o,
  output logic             priv_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle at time zero
  initial begin
    req_o   = 1'h0;
    addr_o  = 32'hffff_ffff;
    write_o = 1'h0;
    priv_o  = 1'h0;
  end

  // one request cycle, then wait (bounded) for done and take the verdict
  task acc(input logic [31:0] a, input logic w, input logic p,
           output logic g, output logic t, output logic iv);
    int n;
    @(posedge clk_i);
    req_o   <= 1'h1;
    addr_o  <= a;
    write_o <= w;
    priv_o  <= p;
    @(posedge clk_i);
    req_o   <= 1'h0;
    addr_o  <= ~a;    // released address shows no stale value
    write_o <= ~w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_i !== 1'h1 && n < 8);
    g  = grant_i;
    t  = trap_i;
    iv = inv_i;
    // no done in time: unknown verdict, so every compare of it fails
    if (done_i !== 1'h1) begin
      g  = 1'hx;
      t  = 1'hx;
      iv = 1'hx;
    end
  endtask : acc
endmodule : smac_core_bfm

// file: testbench/testbench.sv
/*
  Self-checking bench for smac_top: APB master, core model, table of
  core accesses; reset, table, register, interrupt, boot and second reset tests.
  Assumes zero-wait APB answers and a registered core verdict.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [31:0] a;
    logic        w;
    logic        p;
    logic        g;
    logic        iv;
  } smac_row_t;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [2:0]  pprot = 3'h1;
  logic        pready, pslverr, irq, bflash, block;
  logic        req, wr, pv, done, grant, trap, inv;
  logic [31:0] addr, rdv;
  logic        er, g, t, iv;
  int          errors = 0, num_checks = 0;
  smac_row_t   rows [13] = '{
    '{32'h0000_0000, 1'h0, 1'h1, 1'h1, 1'h0},
    '{32'h0000_0100, 1'h0, 1'h0, 1'h0, 1'h0},
    '{32'h0040_0000, 1'h0, 1'h0, 1'h0, 1'h0},
    '{32'h0040_0000, 1'h1, 1'h1, 1'h1, 1'h0},
    '{32'h0030_0000, 1'h0, 1'h1, 1'h0, 1'h1},
    '{32'h0010_0000, 1'h1, 1'h1, 1'h0, 1'h0},
    '{32'h0010_0000, 1'h0, 1'h0, 1'h1, 1'h0},
    '{32'h0018_0000, 1'h0, 1'h0, 1'h0, 1'h0},
    '{32'h0020_0010, 1'h0, 1'h0, 1'h1, 1'h0},
    '{32'h0020_0010, 1'h1, 1'h0, 1'h0, 1'h0},
    '{32'h0020_0100, 1'h0, 1'h0, 1'h0, 1'h0},
    '{32'h0020_3fff, 1'h1, 1'h1, 1'h1, 1'h0},
    '{32'h0020_00ff, 1'h0, 1'h0, 1'h1, 1'h0}};
  logic [11:0] ofs [8] = '{12'h000, 12'h004, 12'h008, 12'h00c,
                           12'h040, 12'h044, 12'h048, 12'h068};

  // clock
  always #50 clk = ~clk;

  smac_top i_smac_top (
    .core_clk_i(clk), .rst_i(rst), .core_req_i(req), .core_addr_i(addr),
    .core_write_i(wr), .core_priv_i(pv), .core_done_o(done),
    .core_grant_o(grant), .core_trap_o(trap), .invalid_addr_o(inv),
    .boot_flash_o(bflash), .boot_locked_o(block), .irq_o(irq),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pprot_i(pprot),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  smac_core_bfm i_smac_core_bfm (
    .clk_i(clk), .done_i(done), .grant_i(grant), .trap_i(trap),
    .inv_i(inv), .req_o(req), .addr_o(addr), .write_o(wr), .priv_o(pv));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    // no answer in time counts as a mismatch and ends the run
    if (pready !== 1'h1) begin
      errors++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      give_verdict();
    end
    rdv = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~d;
  endtask : apb

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(nm, e, rdv);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask : rchk

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // watchdog
  initial begin
    #1_000_000;
    errors++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    foreach (ofs[k]) rchk("reset value", ofs[k], 32'h0);
    chk("boot out", 32'h0, {30'h0, bflash, irq});
    $display("test reset done");
    apb(1'h1, 12'h040, 32'h0010_0000);
    apb(1'h1, 12'h044, 32'h0010_ffff);
    apb(1'h1, 12'h048, 32'h0000_0007);
    apb(1'h1, 12'h060, 32'h0020_0000);
    apb(1'h1, 12'h064, 32'h0020_00ff);
    apb(1'h1, 12'h068, 32'h0000_0003);
    rchk("part limit", 12'h064, 32'h0020_00ff);
    foreach (rows[k]) begin
      i_smac_core_bfm.acc(rows[k].a, rows[k].w, rows[k].p, g, t, iv);
      chk("grant", {31'h0, rows[k].g}, {31'h0, g});
      chk("trap", {31'h0, ~rows[k].g}, {31'h0, t});
      chk("invalid", {31'h0, rows[k].iv}, {31'h0, iv});
    end
    $display("test table done");
    pprot <= 3'h0;
    apb(1'h0, 12'h000, 32'h0);
    chk("user read err", 32'h1, {31'h0, er});
    chk("user read data", 32'h0, rdv);
    apb(1'h1, 12'h000, 32'h0000_0004);
    chk("user write err", 32'h1, {31'h0, er});
    pprot <= 3'h1;
    rchk("ctrl kept", 12'h000, 32'h0);
    apb(1'h0, 12'h04c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test register access done");
    rchk("status all", 12'h004, 32'h0000_001f);
    apb(1'h1, 12'h004, 32'h0000_001f);
    rchk("status clear", 12'h004, 32'h0);
    apb(1'h1, 12'h008, 32'h0000_0002);
    i_smac_core_bfm.acc(32'h0050_0000, 1'h0, 1'h1, g, t, iv);
    repeat (2) @(posedge clk);
    chk("irq set", 32'h1, {31'h0, irq});
    i_smac_core_bfm.acc(32'h0010_0004, 1'h1, 1'h1, g, t, iv);
    rchk("last addr", 12'h00c, 32'h0010_0004);
    rchk("status", 12'h004, 32'h0000_0006);
    apb(1'h1, 12'h004, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    apb(1'h1, 12'h000, 32'h0000_000c);
    i_smac_core_bfm.acc(32'h0010_0004, 1'h1, 1'h1, g, t, iv);
    chk("flash write", 32'h1, {31'h0, g});
    i_smac_core_bfm.acc(32'h0000_fffc, 1'h0, 1'h0, g, t, iv);
    chk("rom user", 32'h1, {31'h0, g});
    apb(1'h1, 12'h000, 32'h0000_000d);
    @(posedge clk);
    chk("boot flash", 32'h2, {30'h0, bflash, block});
    apb(1'h1, 12'h000, 32'h0000_000c);
    @(posedge clk);
    chk("boot rom", 32'h0, {30'h0, bflash, block});
    apb(1'h1, 12'h000, 32'h0000_000f);
    apb(1'h1, 12'h000, 32'h0000_0004);
    @(posedge clk);
    chk("boot locked", 32'h3, {30'h0, bflash, block});
    rchk("ctrl locked", 12'h000, 32'h0000_0007);
    $display("test boot done");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("boot after reset", 32'h0, {30'h0, bflash, block});
    rchk("ctrl after reset", 12'h000, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : testbench
